// file: core/sfq_defines.vh
// constants for the sample queue with readout formats and interrupt pins
// assumes an 8-bit register port and one 200 MHz clock
`ifndef SFQ_DEFINES_VH
`define SFQ_DEFINES_VH

// ==========================================================
// register offsets
`define SFQ_OFS_FLAGS 8'h0B
`define SFQ_OFS_READ_PORT 8'h0D
`define SFQ_OFS_MODE 8'h28
`define SFQ_OFS_COUNT 8'h29
`define SFQ_OFS_P1_LOW 8'h2A
`define SFQ_OFS_P2_LOW 8'h2B
`define SFQ_OFS_P1_HIGH 8'h3A
`define SFQ_OFS_P2_HIGH 8'h3B
`define SFQ_OFS_FORMAT 8'h3C
`define SFQ_OFS_MEAS_EN 8'h3D
`define SFQ_OFS_DATA_A_LO 8'h08
`define SFQ_OFS_DATA_A_HI 8'h0A
`define SFQ_OFS_DATA_B_LO 8'h0E
`define SFQ_OFS_DATA_B_HI 8'h15

// ==========================================================
// reset values
`define SFQ_RST_MODE 8'h00
`define SFQ_RST_COUNT 8'h80
`define SFQ_RST_FORMAT 8'h00
`define SFQ_RST_MAP 8'h00
`define SFQ_RST_MEAS_EN 8'h00

// ==========================================================
// flag bit positions (also map bit positions), then mode and enable register bits
`define SFQ_B_DRDY 0
`define SFQ_B_READY 1
`define SFQ_B_WMARK 2
`define SFQ_B_OVR 3
`define SFQ_B_ACT 4
`define SFQ_B_INACT 5
`define SFQ_B_POL 7
`define SFQ_B_HI_ADC 0
`define SFQ_B_CNT_MSB 2
`define SFQ_B_TEMP_EN 0
`define SFQ_B_ADC_EN 1

// ==========================================================
// queue policies, formats, sample kinds
`define SFQ_POL_OFF 2'h0
`define SFQ_POL_OLDEST 2'h1
`define SFQ_POL_STREAM 2'h2
`define SFQ_POL_TRIG 2'h3
`define SFQ_FMT_TAG14 2'h0
`define SFQ_FMT_TAG12 2'h1
`define SFQ_FMT_PACK8 2'h2
`define SFQ_FMT_PACK12 2'h3
`define SFQ_KIND_TEMP 3'h3
`define SFQ_KIND_ADC 3'h4
`define SFQ_TAG_AUX 2'h3
`define SFQ_GRP_AXES 2'h0
`define SFQ_GRP_TEMP 2'h1
`define SFQ_GRP_ADC 2'h2

`endif

// file: core/sfq_top.v
// sample queue: 512-word array plus holding register, readout formats,
// flag register and two interrupt pins with mapping and polarity.
// assumes producers and register master run on mclk; pins resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "sfq_defines.vh"

// What this block does
// R1 - tagged 14-bit word: two-bit kind tag on top, sample below
// R2 - tagged 12-bit word: tag on top, two sign bits, then 12-bit sample
// R3 - 8-bit packed: upper eight sample bits per byte, no tag
// R4 - 12-bit packed: two untagged samples squeezed into three bytes
// R5 - capacity is 512 array words plus one holding register
// R6 - entries stored as repeating sets in fixed channel order
// R7 - four-bit channel code picks which channels form a set
// R8 - temperature and converter stored only when also enabled
// R9 - host changes channel code only in standby
// R10 - stored samples delivered through the queue read port
// R11 - events for samples present, level reached and overflow
// R12 - each source maps to either pin, pin is OR of sources
// R13 - pin with nothing mapped, and after reset, is undriven
// R14 - pins assert high unless polarity bit asks for low
// R15 - reading flag register clears activity and inactivity
// R16 - reading a data register clears the new-data flag
// R17 - queue flags clear once the condition no longer holds
// R18 - undriven pin keeps its last level
// R19 - host should mask interrupts while configuring them
// R20 - oldest-saved policy stops accepting when full
// R21 - streaming policy drops oldest entry to make room
// R22 - level flag set while count at or above threshold
// R23 - overflow set on loss, cleared by read or disable
module sfq_top #(
	parameter DEPTH_LOG2 = 9,
	parameter SAMPLE_W = 14
) (
	input wire mclk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire smp_valid,
	input wire [2:0] smp_kind,
	input wire [SAMPLE_W-1:0] smp_data,
	input wire new_data_evt,
	input wire act_evt,
	input wire inact_evt,
	input wire adc_evt,
	output reg irq_pin_one_o,
	output reg irq_pin_one_oe,
	output reg irq_pin_two_o,
	output reg irq_pin_two_oe
);
	localparam DEPTH = 1 << DEPTH_LOG2;
	localparam CW = DEPTH_LOG2 + 1;
	localparam [CW-1:0] MEM_FULL = DEPTH[CW-1:0];
	localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
	// readout phase states, one-hot
	localparam [2:0] PH_0 = 3'b001;
	localparam [2:0] PH_1 = 3'b010;
	localparam [2:0] PH_2 = 3'b100;

	// ==========================================================
	// helpers

	// R7 - channel code decode
	// R8 - aux enable gate
	function sel_ok;
		input [3:0] code;
		input [2:0] kind;
		input temp_en;
		input adc_en;
		begin
			case (kind)
				3'h0, 3'h1, 3'h2: begin
					sel_ok = (code[3:2] != 2'h3) &&
						((code[1:0] == 2'h0) || ({1'b0, code[1:0]} == kind + 3'h1));
				end
				`SFQ_KIND_TEMP: sel_ok = (code[3:2] == `SFQ_GRP_TEMP) && temp_en;
				`SFQ_KIND_ADC: sel_ok = (code[3:2] == `SFQ_GRP_ADC) && adc_en;
				default: sel_ok = 1'b0;
			endcase
		end
	endfunction

	// OR of mapped sources for one pin
	function pin_active;
		input [7:0] map_lo;
		input [7:0] map_hi;
		input [5:0] flags;
		input adc_flag;
		begin
			pin_active = (|(map_lo[5:0] & flags)) | (map_hi[`SFQ_B_HI_ADC] & adc_flag);
		end
	endfunction

	// ==========================================================
	// registers
	reg [7:0] mode_q;
	reg [7:0] count_q;
	reg [7:0] format_q;
	reg [7:0] meas_en_q;
	reg [7:0] p1_lo_q;
	reg [7:0] p1_hi_q;
	reg [7:0] p2_lo_q;
	reg [7:0] p2_hi_q;
	reg drdy_q;
	reg act_q;
	reg inact_q;
	reg adc_q;
	reg ovr_q;
	reg [15:0] mem [0:DEPTH-1];
	reg [DEPTH_LOG2-1:0] head_q;
	reg [DEPTH_LOG2-1:0] tail_q;
	reg [CW-1:0] mem_cnt_q;
	reg [15:0] hold_q;
	reg hold_v_q;
	reg [2:0] ph_q;
	reg [7:0] saved_q;

	wire [1:0] policy = mode_q[1:0];
	wire [3:0] chan_code = mode_q[6:3];
	wire [1:0] fmt = format_q[1:0];
	wire [8:0] threshold = {mode_q[`SFQ_B_CNT_MSB], count_q};
	wire disabled = (policy == `SFQ_POL_OFF);

	// ==========================================================
	// queue control
	wire full = (mem_cnt_q == MEM_FULL) && hold_v_q;
	wire [CW:0] total = {1'b0, mem_cnt_q} + {{CW{1'b0}}, hold_v_q};
	wire port_rd = reg_rd && (reg_addr == `SFQ_OFS_READ_PORT);
	wire packed12 = (fmt == `SFQ_FMT_PACK12);
	wire packed8 = (fmt == `SFQ_FMT_PACK8);
	// R10 - pop on port read
	wire pop = port_rd && hold_v_q && (packed8 || (packed12 ? !ph_q[2] : ph_q[1]));
	wire want = smp_valid && !disabled &&
		sel_ok(chan_code, smp_kind, meas_en_q[`SFQ_B_TEMP_EN], meas_en_q[`SFQ_B_ADC_EN]);
	// R21 - stream drops oldest
	wire drop = want && full && (policy != `SFQ_POL_OLDEST);
	wire consume = pop || drop;
	wire to_hold = (mem_cnt_q != CNT_ZERO) && (!hold_v_q || consume);
	// R20 - oldest-saved refuses when full
	wire push = want && (!full || drop);
	// R23 - loss detection
	wire lost = want && full;
	// R1 - tag and 14-bit sample
	wire [1:0] tag = (smp_kind[2] || smp_kind == `SFQ_KIND_TEMP) ? `SFQ_TAG_AUX : smp_kind[1:0];
	wire [15:0] entry = {tag, smp_data};

	// R5 - array plus holding register
	// R6 - writes in arrival order
	always @(posedge mclk) begin
		if (push) begin
			mem[tail_q] <= entry;
		end
	end

	// pointers and counts; disabling flushes everything
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			head_q <= {DEPTH_LOG2{1'b0}};
			tail_q <= {DEPTH_LOG2{1'b0}};
			mem_cnt_q <= CNT_ZERO;
			hold_q <= 16'h0000;
			hold_v_q <= 1'b0;
		end else if (disabled) begin
			head_q <= {DEPTH_LOG2{1'b0}};
			tail_q <= {DEPTH_LOG2{1'b0}};
			mem_cnt_q <= CNT_ZERO;
			hold_v_q <= 1'b0;
		end else begin
			if (push) begin
				tail_q <= tail_q + 1'b1;
			end
			if (to_hold) begin
				hold_q <= mem[head_q];
				head_q <= head_q + 1'b1;
				hold_v_q <= 1'b1;
			end else if (consume) begin
				hold_v_q <= 1'b0;
			end
			case ({push, to_hold})
				2'b10: mem_cnt_q <= mem_cnt_q + 1'b1;
				2'b01: mem_cnt_q <= mem_cnt_q - 1'b1;
				default: mem_cnt_q <= mem_cnt_q;
			endcase
		end
	end

	// ==========================================================
	// readout formatting
	wire [SAMPLE_W-1:0] hs = hold_q[SAMPLE_W-1:0];
	// R2 - sign extended 12-bit
	wire [15:0] tag12 = {hold_q[15:14], {2{hs[SAMPLE_W-1]}}, hs[SAMPLE_W-1:SAMPLE_W-12]};
	wire [15:0] word16 = (fmt == `SFQ_FMT_TAG12) ? tag12 : hold_q;
	// R3 - upper eight bits
	wire [7:0] up8 = hs[SAMPLE_W-1:SAMPLE_W-8];
	wire [11:0] up12 = hs[SAMPLE_W-1:SAMPLE_W-12];
	reg [7:0] port_byte;

	// R4 - three-byte packing
	always @* begin
		port_byte = 8'h00;
		if (packed8) begin
			port_byte = hold_v_q ? up8 : 8'h00;
		end else if (packed12) begin
			case (ph_q)
				PH_0: port_byte = hold_v_q ? up12[7:0] : 8'h00;
				PH_1: port_byte = hold_v_q ? {up12[3:0], saved_q[3:0]} : 8'h00;
				PH_2: port_byte = saved_q;
				default: port_byte = 8'h00;
			endcase
		end else begin
			// tagged words go out high byte first, pop on the low byte
			port_byte = !hold_v_q ? 8'h00 : (ph_q[1] ? word16[7:0] : word16[15:8]);
		end
	end

	// byte phase; an empty read leaves it unchanged except packed tail byte
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ph_q <= PH_0;
			saved_q <= 8'h00;
		end else if (disabled || (reg_wr && reg_addr == `SFQ_OFS_FORMAT)) begin
			ph_q <= PH_0;
		end else if (port_rd && (hold_v_q || ph_q[2])) begin
			case (ph_q)
				PH_0: begin
					saved_q <= {4'h0, up12[11:8]};
					ph_q <= packed8 ? PH_0 : PH_1;
				end
				PH_1: begin
					saved_q <= up12[11:4];
					ph_q <= packed12 ? PH_2 : PH_0;
				end
				PH_2: ph_q <= PH_0;
				default: ph_q <= PH_0;
			endcase
		end
	end

	// ==========================================================
	// event flags
	wire flags_rd = reg_rd && (reg_addr == `SFQ_OFS_FLAGS);
	wire data_rd = reg_rd &&
		(((reg_addr >= `SFQ_OFS_DATA_A_LO) && (reg_addr <= `SFQ_OFS_DATA_A_HI)) ||
		((reg_addr >= `SFQ_OFS_DATA_B_LO) && (reg_addr <= `SFQ_OFS_DATA_B_HI)));
	// R11 - queue events
	// R22 - level compare
	// R17 - self clearing conditions
	wire wmark = (total >= {1'b0, threshold});
	wire [5:0] flags = {inact_q, act_q, ovr_q, wmark, hold_v_q, drdy_q};

	// sticky flags: a set in the same cycle as its clear wins
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			drdy_q <= 1'b0;
			act_q <= 1'b0;
			inact_q <= 1'b0;
			adc_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			// R16 - data read clears new-data
			drdy_q <= new_data_evt | (drdy_q & ~data_rd);
			// R15 - flag read clears motion
			act_q <= act_evt | (act_q & ~flags_rd);
			inact_q <= inact_evt | (inact_q & ~flags_rd);
			adc_q <= adc_evt | (adc_q & ~flags_rd);
			// R23 - overflow set and clear
			ovr_q <= !disabled && (lost | (ovr_q & ~pop));
		end
	end

	// ==========================================================
	// register port
	// R9 - channel code kept as written; host changes it in standby
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q <= `SFQ_RST_MODE;
			count_q <= `SFQ_RST_COUNT;
			format_q <= `SFQ_RST_FORMAT;
			meas_en_q <= `SFQ_RST_MEAS_EN;
			p1_lo_q <= `SFQ_RST_MAP;
			p1_hi_q <= `SFQ_RST_MAP;
			p2_lo_q <= `SFQ_RST_MAP;
			p2_hi_q <= `SFQ_RST_MAP;
		end else if (reg_wr) begin
			case (reg_addr)
				`SFQ_OFS_MODE: mode_q <= reg_wdata;
				`SFQ_OFS_COUNT: count_q <= reg_wdata;
				`SFQ_OFS_FORMAT: format_q <= reg_wdata;
				`SFQ_OFS_MEAS_EN: meas_en_q <= reg_wdata;
				`SFQ_OFS_P1_LOW: p1_lo_q <= reg_wdata;
				`SFQ_OFS_P1_HIGH: p1_hi_q <= reg_wdata;
				`SFQ_OFS_P2_LOW: p2_lo_q <= reg_wdata;
				`SFQ_OFS_P2_HIGH: p2_hi_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped offsets read zero
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`SFQ_OFS_FLAGS: reg_rdata <= {1'b0, adc_q, flags};
				`SFQ_OFS_READ_PORT: reg_rdata <= port_byte;
				`SFQ_OFS_MODE: reg_rdata <= mode_q;
				`SFQ_OFS_COUNT: reg_rdata <= count_q;
				`SFQ_OFS_FORMAT: reg_rdata <= format_q;
				`SFQ_OFS_MEAS_EN: reg_rdata <= meas_en_q;
				`SFQ_OFS_P1_LOW: reg_rdata <= p1_lo_q;
				`SFQ_OFS_P1_HIGH: reg_rdata <= p1_hi_q;
				`SFQ_OFS_P2_LOW: reg_rdata <= p2_lo_q;
				`SFQ_OFS_P2_HIGH: reg_rdata <= p2_hi_q;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// interrupt pins
	wire one_act = pin_active(p1_lo_q, p1_hi_q, flags, adc_q);
	wire two_act = pin_active(p2_lo_q, p2_hi_q, flags, adc_q);
	wire one_map = (|p1_lo_q[5:0]) | p1_hi_q[`SFQ_B_HI_ADC];
	wire two_map = (|p2_lo_q[5:0]) | p2_hi_q[`SFQ_B_HI_ADC];

	// pins registered; level frozen while undriven so the keeper holds it
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_pin_one_o <= 1'b0;
			irq_pin_two_o <= 1'b0;
			irq_pin_one_oe <= 1'b0;
			irq_pin_two_oe <= 1'b0;
		end else begin
			// R13 - unmapped pin undriven
			irq_pin_one_oe <= one_map;
			irq_pin_two_oe <= two_map;
			// R12 - OR of mapped sources
			// R14 - polarity select
			// R18 - last level kept
			if (one_map) begin
				irq_pin_one_o <= one_act ^ p1_lo_q[`SFQ_B_POL];
			end
			if (two_map) begin
				irq_pin_two_o <= two_act ^ p2_lo_q[`SFQ_B_POL];
			end
		end
	end

endmodule
`default_nettype wire

// file: test/sfq_checker_asserts.sv
// checker for the sample queue top: register port and interrupt pins
// assumes one clock, async active-high reset, map writes seen on the port
`timescale 1ns/1ps
`default_nettype none
`include "sfq_defines.vh"
module sfq_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic new_data_evt,
	input wire logic act_evt,
	input wire logic inact_evt,
	input wire logic irq_pin_one_o,
	input wire logic irq_pin_one_oe,
	input wire logic irq_pin_two_o,
	input wire logic irq_pin_two_oe
);
	logic [7:0] m1l_q, m1h_q, m2l_q, m2h_q;
	logic want1, want2;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========================================================
	// shadow maps
	// copies of the map registers, so pin enables can be predicted
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			m1l_q <= 8'h00;
			m1h_q <= 8'h00;
			m2l_q <= 8'h00;
			m2h_q <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == `SFQ_OFS_P1_LOW) m1l_q <= reg_wdata;
			if (reg_addr == `SFQ_OFS_P1_HIGH) m1h_q <= reg_wdata;
			if (reg_addr == `SFQ_OFS_P2_LOW) m2l_q <= reg_wdata;
			if (reg_addr == `SFQ_OFS_P2_HIGH) m2h_q <= reg_wdata;
		end
	end
	// polarity bit alone does not enable a pin
	assign want1 = |m1l_q[5:0] | m1h_q[0];
	assign want2 = |m2l_q[5:0] | m2h_q[0];
	// ==========================================================
	// properties
	sequence flag_rd;
		reg_rd && reg_addr == `SFQ_OFS_FLAGS && !act_evt && !inact_evt;
	endsequence
	sequence data_rd;
		reg_rd && reg_addr == `SFQ_OFS_DATA_A_LO && !new_data_evt;
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (
		reg_rd && (reg_addr == 8'h40 || reg_addr == `SFQ_OFS_DATA_A_LO) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_oe_one: assert property (
		$past(want1) == want1 && $past(want1, 2) == want1 |-> irq_pin_one_oe == want1)
		else $error("pin one enable does not follow its map");
	a_oe_two: assert property (
		$past(want2) == want2 && $past(want2, 2) == want2 |-> irq_pin_two_oe == want2)
		else $error("pin two enable does not follow its map");
	a_keep_one: assert property (
		!irq_pin_one_oe && !$past(irq_pin_one_oe) |-> $stable(irq_pin_one_o))
		else $error("pin one level moved while undriven");
	a_keep_two: assert property (
		!irq_pin_two_oe && !$past(irq_pin_two_oe) |-> $stable(irq_pin_two_o))
		else $error("pin two level moved while undriven");
	a_motion_read_clear: assert property (
		flag_rd ##1 !act_evt && !inact_evt ##1 flag_rd |=> reg_rdata[5:4] == 2'h0)
		else $error("motion flags survive a flag read");
	a_drdy_read_clear: assert property (
		data_rd ##1 !new_data_evt [*4] ##1 reg_rd && reg_addr == `SFQ_OFS_FLAGS
		&& !new_data_evt |=> !reg_rdata[0])
		else $error("new-data flag survives a data read");
endmodule
bind sfq_top sfq_checker u_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.new_data_evt(new_data_evt), .act_evt(act_evt), .inact_evt(inact_evt),
	.irq_pin_one_o(irq_pin_one_o), .irq_pin_one_oe(irq_pin_one_oe),
	.irq_pin_two_o(irq_pin_two_o), .irq_pin_two_oe(irq_pin_two_oe));
`default_nettype wire

// file: test/sfq_host_pins.sv
// host side of one interrupt pin: the wire level the host sees
// assumes pin drive and enable come straight from the queue block
`timescale 1ns/1ps
`default_nettype none
module sfq_host_pins (
	input wire logic mclk,
	input wire logic o,
	input wire logic oe,
	output logic line
);
	logic kept_q;
	always @(posedge mclk) if (oe) kept_q <= o;
	// undriven line shows the kept level, unknown before first drive
	assign line = oe ? o : kept_q;
endmodule
`default_nettype wire

// file: test/tb_sample_fifo_readout_and_irq_pins.sv
// self-checking bench for the sample queue: formats, channels, policies, pins
// assumes the design header and the host pin model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sfq_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_sample_fifo_readout_and_irq_pins;
	localparam logic [7:0] rp = `SFQ_OFS_READ_PORT, fl = `SFQ_OFS_FLAGS, md = `SFQ_OFS_MODE;
	logic mclk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, smp_valid = 1'h0;
	logic new_data_evt = 1'h0, act_evt = 1'h0, o1, oe1, o2, oe2, line1, line2;
	logic inact_evt = 1'h0, adc_evt = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
	logic [2:0] smp_kind = 3'h0;
	logic [13:0] smp_data = 14'h0000;
	logic [13:0] s [5];
	logic [15:0] w;
	logic [31:0] seed = 32'h0001067B;
	int fails = 0, cmp_count = 0, f, i, m;
	always #2.5 mclk = ~mclk;
	// ==========================================================
	// design and host pins
	sfq_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
		.smp_kind(smp_kind), .smp_data(smp_data), .new_data_evt(new_data_evt),
		.act_evt(act_evt), .inact_evt(inact_evt), .adc_evt(adc_evt), .irq_pin_one_o(o1),
		.irq_pin_one_oe(oe1), .irq_pin_two_o(o2), .irq_pin_two_oe(oe2));
	sfq_host_pins host1 (.mclk(mclk), .o(o1), .oe(oe1), .line(line1));
	sfq_host_pins host2 (.mclk(mclk), .o(o2), .oe(oe2), .line(line2));
	// ==========================================================
	// helpers
	function automatic logic [13:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[13:0];
	endfunction
	// tagged word; temperature and converter share the aux tag
	function automatic logic [15:0] word(input int f, input logic [2:0] k, input logic [13:0] d);
		logic [1:0] t;
		t = (k < 3) ? k[1:0] : `SFQ_TAG_AUX;
		return f ? {t, {3{d[13]}}, d[12:2]} : {t, d};
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	// data is only valid in the cycle after the strobe, so sample just past that edge
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task push(input logic [2:0] k, input logic [13:0] d);
		@(posedge mclk);
		smp_valid <= 1'h1;
		smp_kind <= k;
		smp_data <= d;
		@(posedge mclk);
		smp_valid <= 1'h0;
	endtask
	task settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// watchdog, well past the few thousand cycles the sequence needs
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_of_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		`CHK({oe1, oe2}, 2'h0)
		rd(`SFQ_OFS_COUNT, v); `CHK(v, `SFQ_RST_COUNT)
		rd(md, v); `CHK(v, `SFQ_RST_MODE)
		rd(`SFQ_OFS_FORMAT, v); `CHK(v, `SFQ_RST_FORMAT)
		rd(8'h40, v); `CHK(v, 8'h00)
		wr(`SFQ_OFS_MEAS_EN, 8'h01);
		// every readout format on a z sample and a temperature sample
		for (f = 0; f < 4; f++) begin
			// channel code only changed with the queue off
			wr(md, 8'h00);
			wr(`SFQ_OFS_FORMAT, f[7:0]);
			wr(md, 8'h22);
			for (i = 0; i < 2; i++) begin
				s[i] = rnd();
				push(3'(i + 2), s[i]);
			end
			if (f < 2) begin
				for (i = 0; i < 2; i++) begin
					w = word(f, 3'(i + 2), s[i]);
					rd(rp, v); `CHK(v, w[15:8])
					rd(rp, v); `CHK(v, w[7:0])
				end
			end else if (f == 2) begin
				for (i = 0; i < 2; i++) begin
					rd(rp, v); `CHK(v, s[i][13:6])
				end
			end else begin
				rd(rp, v); `CHK(v, s[0][9:2])
				rd(rp, v); `CHK(v, {s[1][5:2], s[0][13:10]})
				rd(rp, v); `CHK(v, s[1][13:6])
			end
		end
		// unselected axis, then temperature without its enable, are dropped
		wr(`SFQ_OFS_FORMAT, 8'h00);
		wr(`SFQ_OFS_MEAS_EN, 8'h00);
		for (m = 0; m < 2; m++) begin
			wr(md, 8'h00);
			wr(md, m ? 8'h22 : 8'h0A);
			s[0] = rnd();
			push(m ? 3'h3 : 3'h1, ~s[0]);
			push(3'h0, s[0]);
			rd(rp, v); `CHK(v, {2'h0, s[0][13:8]})
			rd(rp, v); `CHK(v, s[0][7:0])
			rd(rp, v); `CHK(v, 8'h00)
		end
		// code 1000: all axes plus converter, temperature left out; policy 3 runs as stream
		wr(md, 8'h00);
		wr(`SFQ_OFS_MEAS_EN, 8'h03);
		wr(md, 8'h43);
		for (i = 0; i < 5; i++) begin
			s[i] = rnd();
			push(3'(i), s[i]);
		end
		for (i = 0; i < 5; i++) begin
			if (i != 3) begin
				w = word(0, 3'(i), s[i]);
				rd(rp, v); `CHK(v, w[15:8])
				rd(rp, v); `CHK(v, w[7:0])
			end
		end
		rd(rp, v); `CHK(v, 8'h00)
		// one past capacity: oldest-saved keeps sample 0, streaming drops it
		for (m = 1; m < 3; m++) begin
			wr(md, 8'h00);
			wr(md, m[7:0]);
			for (i = 0; i < 514; i++) push(3'h0, 14'(i));
			rd(fl, v); `CHK(v[3:1], 3'h7)
			rd(rp, v); `CHK(v, 8'h00)
			rd(rp, v); `CHK(v, 8'(m - 1))
			rd(fl, v); `CHK(v[3], 1'h0)
		end
		// level flag follows the stored count across the threshold
		wr(md, 8'h00);
		wr(`SFQ_OFS_COUNT, 8'h03);
		wr(md, 8'h02);
		for (i = 0; i < 3; i++) begin
			push(3'h0, rnd());
			rd(fl, v); `CHK(v[2], i == 2)
		end
		rd(rp, v);
		rd(rp, v);
		rd(fl, v); `CHK(v[2], 1'h0)
		// maps programmed while no mapped event is pending
		wr(`SFQ_OFS_P1_LOW, 8'h01);
		wr(`SFQ_OFS_P2_LOW, 8'h91);
		@(posedge mclk);
		new_data_evt <= 1'h1;
		act_evt <= 1'h1;
		@(posedge mclk);
		new_data_evt <= 1'h0;
		act_evt <= 1'h0;
		settle();
		`CHK({oe1, line1, oe2, line2}, 4'hE)
		rd(`SFQ_OFS_DATA_A_LO, v); `CHK(v, 8'h00)
		settle();
		`CHK({line1, line2}, 2'h0)
		rd(fl, v); `CHK(v[4], 1'h1)
		rd(fl, v); `CHK(v[4], 1'h0)
		settle();
		`CHK(line2, 1'h1)
		// converter flag through the upper map, inactivity through the lower one
		wr(`SFQ_OFS_P2_LOW, 8'hA0);
		wr(`SFQ_OFS_P2_HIGH, 8'h01);
		@(posedge mclk);
		adc_evt <= 1'h1;
		@(posedge mclk);
		adc_evt <= 1'h0;
		settle();
		`CHK(line2, 1'h0)
		rd(fl, v); `CHK(v[6:5], 2'h2)
		@(posedge mclk);
		inact_evt <= 1'h1;
		@(posedge mclk);
		inact_evt <= 1'h0;
		settle();
		`CHK({line2, o2}, 2'h0)
		rd(fl, v); `CHK(v[6:5], 2'h1)
		settle();
		`CHK(line2, 1'h1)
		// raise pin one's idle level first, so a release to zero would be caught
		wr(`SFQ_OFS_P1_LOW, 8'h81);
		wr(`SFQ_OFS_P1_LOW, 8'h80);
		settle();
		`CHK({oe1, line1, o1}, 3'h3)
		end_of_test();
	end
endmodule
`default_nettype wire
